/* File: common/art_pkg.sv */
// ----------------------------------------------------------------------------
// Alarm relay timing: shared constants and types
// ----------------------------------------------------------------------------
package art_pkg;

	// Clock and time base
	localparam int unsigned ART_CLOCK_HZ       = 100_000_000;
	localparam int unsigned ART_TICK_PERIOD_S  = 1;
	localparam int unsigned ART_SECOND_CYCLES  = ART_CLOCK_HZ * ART_TICK_PERIOD_S;
	localparam int unsigned ART_PRESC_W        = 27;
	localparam int unsigned ART_MINUTE_S       = 60;
	localparam int unsigned ART_RESTORE_HOLD_S = 3;
	localparam int unsigned ART_RESTART_CYCLES = 16;

	// Relay count and field widths
	localparam int unsigned ART_RELAYS   = 3;
	localparam int unsigned ART_CHANNELS = 8;
	localparam int unsigned ART_DELAY_W  = 5;
	localparam int unsigned ART_SEC_W    = 11;
	localparam int unsigned ART_PAR_W    = 8;

	// Delay setting codes
	localparam logic [4:0] ART_DELAY_NONE  = 5'h00;
	localparam logic [4:0] ART_OFF_LATCHED = 5'h1f;

	// Factory defaults
	localparam logic [4:0] ART_DEF_ON_DELAY  = 5'h00;
	localparam logic [4:0] ART_DEF_OFF_DELAY = 5'h1f;
	localparam logic [7:0] ART_DEF_CHAN_USED = 8'h0f;
	localparam logic [2:0] ART_DEF_AUX_MODE  = 3'h0;
	localparam logic [7:0] ART_DEF_LEVEL1    = 8'h0a;
	localparam logic [7:0] ART_DEF_LEVEL2    = 8'h0f;
	localparam logic [7:0] ART_DEF_LEVEL3    = 8'h14;
	localparam logic [7:0] ART_DEF_HYST      = 8'h03;

	// Parameter write addresses
	localparam logic [3:0] ART_ADR_ON0   = 4'h0;
	localparam logic [3:0] ART_ADR_OFF0  = 4'h3;
	localparam logic [3:0] ART_ADR_USED  = 4'h6;
	localparam logic [3:0] ART_ADR_AUX   = 4'h7;
	localparam logic [3:0] ART_ADR_LVL1  = 4'h8;
	localparam logic [3:0] ART_ADR_LVL2  = 4'h9;
	localparam logic [3:0] ART_ADR_LVL3  = 4'ha;
	localparam logic [3:0] ART_ADR_HYST  = 4'hb;

	typedef enum logic [1:0] {
		ART_ST_IDLE     = 2'b00,
		ART_ST_ON_WAIT  = 2'b01,
		ART_ST_ACTIVE   = 2'b10,
		ART_ST_OFF_WAIT = 2'b11
	} art_chan_e;

	typedef enum logic [1:0] {
		ART_RS_RUN     = 2'b00,
		ART_RS_HOLD    = 2'b01,
		ART_RS_RESTART = 2'b10
	} art_rst_e;

	// Delay setting in minutes to a count of seconds
	function automatic logic [10:0] art_delay_seconds(input logic [4:0] minutes);
		art_delay_seconds = {6'h00, minutes} * 11'd60;
	endfunction : art_delay_seconds

endpackage : art_pkg

/* File: common/art_relay_if.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Control to relay channel carrier
// ----------------------------------------------------------------------------
interface art_relay_if;
	logic       alarm;
	logic       enable;
	logic       clear;
	logic       sec_tick;
	logic [4:0] on_delay;
	logic [4:0] off_delay;
	logic       relay;

	modport ctrl (
		output alarm,
		output enable,
		output clear,
		output sec_tick,
		output on_delay,
		output off_delay,
		input  relay
	);

	modport chan (
		input  alarm,
		input  enable,
		input  clear,
		input  sec_tick,
		input  on_delay,
		input  off_delay,
		output relay
	);
endinterface : art_relay_if
`default_nettype wire

/* File: rtl/art_relay_channel.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// One relay: activation delay, deactivation delay or latch
// ----------------------------------------------------------------------------
module art_relay_channel
	import art_pkg::*;
(
	// Clock and reset
	input  wire logic  i_clock,
	input  wire logic  i_rst_n,
	// Control side
	art_relay_if.chan  rif
);

	art_chan_e        state_reg;
	art_chan_e        state_next;
	logic [10:0]      cnt_reg;
	logic [10:0]      cnt_next;
	logic             relay_reg;

	// Delay targets in seconds and elapsed-time decode
	wire logic [10:0] on_secs  = art_delay_seconds(rif.on_delay);
	wire logic [10:0] off_secs = art_delay_seconds(rif.off_delay);
	wire logic [10:0] cnt_inc  = cnt_reg + 11'h001;
	wire logic        on_done  = rif.sec_tick && (cnt_inc >= on_secs);
	wire logic        off_done = rif.sec_tick && (cnt_inc >= off_secs);
	wire logic        latched  = (rif.off_delay == ART_OFF_LATCHED);

	// Next state; a disabled channel is forced idle and forgets its timers
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		if (!rif.enable) begin
			state_next = ART_ST_IDLE;
			cnt_next   = 11'h000;
		end else begin
			unique case (state_reg)
				ART_ST_IDLE: begin
					cnt_next = 11'h000;
					if (rif.alarm) begin
						if (rif.on_delay == ART_DELAY_NONE) begin
							state_next = ART_ST_ACTIVE;
						end else begin
							state_next = ART_ST_ON_WAIT;
						end
					end
				end
				ART_ST_ON_WAIT: begin
					if (!rif.alarm) begin
						state_next = ART_ST_IDLE;
					end else if (on_done) begin
						state_next = ART_ST_ACTIVE;
						cnt_next   = 11'h000;
					end else if (rif.sec_tick) begin
						cnt_next = cnt_inc;
					end
				end
				ART_ST_ACTIVE: begin
					cnt_next = 11'h000;
					if (rif.clear) begin
						state_next = ART_ST_IDLE;
					end else if (!rif.alarm && !latched) begin
						if (rif.off_delay == ART_DELAY_NONE) begin
							state_next = ART_ST_IDLE;
						end else begin
							state_next = ART_ST_OFF_WAIT;
						end
					end
				end
				ART_ST_OFF_WAIT: begin
					if (rif.clear) begin
						state_next = ART_ST_IDLE;
					end else if (rif.alarm) begin
						state_next = ART_ST_ACTIVE;
						cnt_next   = 11'h000;
					end else if (off_done) begin
						state_next = ART_ST_IDLE;
					end else if (rif.sec_tick) begin
						cnt_next = cnt_inc;
					end
				end
			endcase
		end
	end

	// State, timer and relay drive; relay follows the next state so that a
	// zero activation delay energises on the same edge as the alarm is seen
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= ART_ST_IDLE;
			cnt_reg   <= 11'h000;
			relay_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			relay_reg <= (state_next == ART_ST_ACTIVE) || (state_next == ART_ST_OFF_WAIT);
		end
	end

	assign rif.relay = relay_reg;

endmodule : art_relay_channel
`default_nettype wire

/* File: rtl/alarm_relay_timing.sv */
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Three relays, latched by default after power-up
// - Activation delay one to thirty-one minutes
// - Zero activation delay switches relay immediately
// - Release setting 31 latches until reset
// - Release settings 1-30 wait that many minutes
// - Zero release setting drops relay immediately
// - Each relay has independent delay settings
// - Reset held entering programming restores defaults
// - Restore restarts like a power-up
// - Restore sets delays to zero and 31
// - Restore sets channels, thresholds, auxiliary defaults
// - No alarm operation while key programs
// ----------------------------------------------------------------------------
// Alarm relay timing top
// ----------------------------------------------------------------------------
module alarm_relay_timing
	import art_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SECOND = ART_SECOND_CYCLES,
	parameter int unsigned RESTORE_HOLD_S    = ART_RESTORE_HOLD_S
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// Threshold comparator outputs
	input  wire logic [2:0]  i_threshold_output,
	// Front panel
	input  wire logic        i_programming_key_position,
	input  wire logic        i_reset_button,
	// Parameter programming port
	input  wire logic        i_par_write,
	input  wire logic [3:0]  i_par_addr,
	input  wire logic [7:0]  i_par_data,
	// Relay drivers
	output logic      [2:0]  o_relay,
	// Stored timing parameters
	output logic      [14:0] o_on_delay,
	output logic      [14:0] o_off_delay,
	// Stored channel parameters
	output logic      [7:0]  o_channel_used,
	output logic      [2:0]  o_auxiliary_relay_mode,
	output logic      [7:0]  o_first_alarm_threshold,
	output logic      [7:0]  o_second_alarm_threshold,
	output logic      [7:0]  o_third_alarm_threshold,
	output logic      [7:0]  o_hysteresis,
	// Status
	output logic             o_monitoring,
	output logic             o_restore_hold,
	output logic             o_restarting
);

	// ------------------------------------------------------------------------
	// Second prescaler
	// ------------------------------------------------------------------------
	localparam logic [26:0] PRESC_LAST  = 27'(CYCLES_PER_SECOND - 1);
	localparam logic [3:0]  HOLD_LAST   = 4'(RESTORE_HOLD_S - 1);
	localparam logic [4:0]  RESTART_LAST = 5'(ART_RESTART_CYCLES - 1);

	logic [ART_PRESC_W-1:0] presc_reg;
	logic                   sec_tick_reg;

	wire logic presc_wrap = (presc_reg == PRESC_LAST);

	// Free-running base keeps one counter for all relays; a delay therefore
	// ends up to one second early, well inside the ten percent window
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			presc_reg    <= '0;
			sec_tick_reg <= 1'b0;
		end else begin
			presc_reg    <= presc_wrap ? '0 : presc_reg + 27'h0000001;
			sec_tick_reg <= presc_wrap;
		end
	end

	// ------------------------------------------------------------------------
	// Front panel edges and factory restore sequence
	// ------------------------------------------------------------------------
	art_rst_e   rs_reg;
	art_rst_e   rs_next;
	logic [3:0] hold_reg;
	logic [3:0] hold_next;
	logic [4:0] rstc_reg;
	logic [4:0] rstc_next;
	logic       key_q_reg;
	logic       btn_q_reg;

	wire logic key_rise    = i_programming_key_position && !key_q_reg;
	wire logic btn_rise    = i_reset_button && !btn_q_reg;
	wire logic hold_lost   = !i_programming_key_position || !i_reset_button;
	wire logic hold_done   = sec_tick_reg && (hold_reg == HOLD_LAST);
	wire logic do_restore  = (rs_reg == ART_RS_HOLD) && !hold_lost && hold_done;

	// Restore sequence: arm on key entry with the button held, erase after the
	// hold time, then run a short soft restart like a supply return
	always_comb begin
		rs_next   = rs_reg;
		hold_next = hold_reg;
		rstc_next = rstc_reg;
		unique case (rs_reg)
			ART_RS_RUN: begin
				hold_next = 4'h0;
				if (key_rise && i_reset_button) begin
					rs_next = ART_RS_HOLD;
				end
			end
			ART_RS_HOLD: begin
				if (hold_lost) begin
					rs_next = ART_RS_RUN;
				end else if (hold_done) begin
					rs_next   = ART_RS_RESTART;
					rstc_next = 5'h00;
				end else if (sec_tick_reg) begin
					hold_next = hold_reg + 4'h1;
				end
			end
			ART_RS_RESTART: begin
				if (rstc_reg == RESTART_LAST) begin
					rs_next = ART_RS_RUN;
				end else begin
					rstc_next = rstc_reg + 5'h01;
				end
			end
			default: begin
				rs_next = ART_RS_RUN;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rs_reg    <= ART_RS_RUN;
			hold_reg  <= 4'h0;
			rstc_reg  <= 5'h00;
			key_q_reg <= 1'b0;
			btn_q_reg <= 1'b0;
		end else begin
			rs_reg    <= rs_next;
			hold_reg  <= hold_next;
			rstc_reg  <= rstc_next;
			key_q_reg <= i_programming_key_position;
			btn_q_reg <= i_reset_button;
		end
	end

	// ------------------------------------------------------------------------
	// Parameter store
	// ------------------------------------------------------------------------
	logic [4:0] on_reg   [ART_RELAYS];
	logic [4:0] off_reg  [ART_RELAYS];
	logic [7:0] used_reg;
	logic [2:0] aux_reg;
	logic [7:0] lvl1_reg;
	logic [7:0] lvl2_reg;
	logic [7:0] lvl3_reg;
	logic [7:0] hyst_reg;

	// Edits only from the programming key and never during a restore
	wire logic par_we = i_par_write && i_programming_key_position && (rs_reg == ART_RS_RUN);

	// Power-up and factory restore both land on the same defaults
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			used_reg <= ART_DEF_CHAN_USED;
			aux_reg  <= ART_DEF_AUX_MODE;
			lvl1_reg <= ART_DEF_LEVEL1;
			lvl2_reg <= ART_DEF_LEVEL2;
			lvl3_reg <= ART_DEF_LEVEL3;
			hyst_reg <= ART_DEF_HYST;
		end else if (do_restore) begin
			used_reg <= ART_DEF_CHAN_USED;
			aux_reg  <= ART_DEF_AUX_MODE;
			lvl1_reg <= ART_DEF_LEVEL1;
			lvl2_reg <= ART_DEF_LEVEL2;
			lvl3_reg <= ART_DEF_LEVEL3;
			hyst_reg <= ART_DEF_HYST;
		end else if (par_we) begin
			if (i_par_addr == ART_ADR_USED) used_reg <= i_par_data;
			if (i_par_addr == ART_ADR_AUX)  aux_reg  <= i_par_data[2:0];
			if (i_par_addr == ART_ADR_LVL1) lvl1_reg <= i_par_data;
			if (i_par_addr == ART_ADR_LVL2) lvl2_reg <= i_par_data;
			if (i_par_addr == ART_ADR_LVL3) lvl3_reg <= i_par_data;
			if (i_par_addr == ART_ADR_HYST) hyst_reg <= i_par_data;
		end
	end

	// ------------------------------------------------------------------------
	// Relay channels
	// ------------------------------------------------------------------------
	art_relay_if rif [ART_RELAYS] ();

	// Alarm operation stops while the key programs or a restart runs
	wire logic run_ok = !i_programming_key_position && (rs_reg == ART_RS_RUN);

	genvar g;
	generate
		for (g = 0; g < ART_RELAYS; g++) begin : g_relay
			wire logic on_we  = par_we && (i_par_addr == ART_ADR_ON0 + 4'(g));
			wire logic off_we = par_we && (i_par_addr == ART_ADR_OFF0 + 4'(g));

			// Each relay keeps its own pair of delays
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					on_reg[g]  <= ART_DEF_ON_DELAY;
					off_reg[g] <= ART_DEF_OFF_DELAY;
				end else if (do_restore) begin
					on_reg[g]  <= ART_DEF_ON_DELAY;
					off_reg[g] <= ART_DEF_OFF_DELAY;
				end else begin
					if (on_we)  on_reg[g]  <= i_par_data[4:0];
					if (off_we) off_reg[g] <= i_par_data[4:0];
				end
			end

			assign rif[g].alarm     = i_threshold_output[g];
			assign rif[g].enable    = run_ok;
			assign rif[g].clear     = btn_rise;
			assign rif[g].sec_tick  = sec_tick_reg;
			assign rif[g].on_delay  = on_reg[g];
			assign rif[g].off_delay = off_reg[g];

			art_relay_channel u_chan (
				.i_clock (i_clock),
				.i_rst_n (i_rst_n),
				.rif     (rif[g])
			);

			assign o_relay[g]             = rif[g].relay;
			assign o_on_delay[5*g +: 5]   = on_reg[g];
			assign o_off_delay[5*g +: 5]  = off_reg[g];
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Status and parameter outputs
	// ------------------------------------------------------------------------
	assign o_channel_used           = used_reg;
	assign o_auxiliary_relay_mode   = aux_reg;
	assign o_first_alarm_threshold  = lvl1_reg;
	assign o_second_alarm_threshold = lvl2_reg;
	assign o_third_alarm_threshold  = lvl3_reg;
	assign o_hysteresis             = hyst_reg;
	assign o_monitoring             = run_ok;
	assign o_restore_hold           = (rs_reg == ART_RS_HOLD);
	assign o_restarting             = (rs_reg == ART_RS_RESTART);

endmodule : alarm_relay_timing
`default_nettype wire

/* File: tb/art_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Relay timing checks at the top ports
// ----------------------------------------------------------------------------
module art_properties
	import art_pkg::*;
#(
	parameter int unsigned CYCLES_PER_SECOND = ART_SECOND_CYCLES,
	parameter int unsigned RESTORE_HOLD_S    = ART_RESTORE_HOLD_S
) (
	// Clock and reset
	input wire logic        i_clock,
	input wire logic        i_rst_n,
	// Panel side
	input wire logic [2:0]  i_threshold_output,
	input wire logic        i_programming_key_position,
	input wire logic        i_reset_button,
	// Relay and parameter side
	input wire logic [2:0]  o_relay,
	input wire logic [14:0] o_on_delay,
	input wire logic [14:0] o_off_delay,
	input wire logic [7:0]  o_channel_used,
	input wire logic [2:0]  o_auxiliary_relay_mode,
	input wire logic [7:0]  o_first_alarm_threshold,
	input wire logic [7:0]  o_second_alarm_threshold,
	input wire logic [7:0]  o_third_alarm_threshold,
	input wire logic [7:0]  o_hysteresis,
	input wire logic        o_monitoring,
	input wire logic        o_restore_hold,
	input wire logic        o_restarting
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	logic [31:0] on_run_reg, on_run_next, off_run_reg, off_run_next, hold_reg, hold_next;
	logic [31:0] on_min, on_max, off_min, off_max;

	// Run lengths; one second of slack absorbs the free-running second tick, plus two cycles below and four above
	assign on_run_next  = (i_threshold_output[1] && o_monitoring && !i_reset_button) ?
		on_run_reg + 32'h1 : 32'h0;
	assign off_run_next = (o_relay[2] && !i_threshold_output[2]) ? off_run_reg + 32'h1 : 32'h0;
	assign hold_next    = o_restore_hold ? hold_reg + 32'h1 : 32'h0;
	assign on_min  = ({27'h0, o_on_delay[9:5]} * 32'h3c - 32'h1) * CYCLES_PER_SECOND - 32'h2;
	assign on_max  = {27'h0, o_on_delay[9:5]} * 32'h3c * CYCLES_PER_SECOND + 32'h4;
	assign off_min = ({27'h0, o_off_delay[14:10]} * 32'h3c - 32'h1) * CYCLES_PER_SECOND - 32'h2;
	assign off_max = {27'h0, o_off_delay[14:10]} * 32'h3c * CYCLES_PER_SECOND + 32'h4;

	// Counter registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			on_run_reg  <= 32'h0;
			off_run_reg <= 32'h0;
			hold_reg    <= 32'h0;
		end else begin
			on_run_reg  <= on_run_next;
			off_run_reg <= off_run_next;
			hold_reg    <= hold_next;
		end
	end

	sequence key_held_s;
		i_programming_key_position ##1 i_programming_key_position;
	endsequence
	sequence restart_run_s;
		o_restarting[*8] ##1 o_restarting[*8] ##1 !o_restarting;
	endsequence

	AST_INSTANT_ON: assert property (
		o_monitoring && i_threshold_output[0] && o_on_delay[4:0] == 5'h00 && !i_reset_button
		&& !o_relay[0] |=> o_relay[0]) else $error("Relay 0 did not switch on at once");
	AST_ON_NOT_EARLY: assert property (
		$rose(o_relay[1]) && o_on_delay[9:5] != 5'h00 |-> on_run_reg >= on_min)
		else $error("Relay 1 switched on before its delay");
	AST_ON_IN_TIME: assert property (
		on_run_reg == on_max && o_on_delay[9:5] != 5'h00 |-> o_relay[1])
		else $error("Relay 1 late after its delay");
	AST_IMM_OFF: assert property (
		o_relay[1] && !i_threshold_output[1] && o_off_delay[9:5] == 5'h00 |=> !o_relay[1])
		else $error("Relay 1 did not release at once");
	AST_LATCH_HOLD: assert property (
		o_relay[0] && o_off_delay[4:0] == 5'h1f && o_monitoring && !i_reset_button |=> o_relay[0])
		else $error("Latched relay 0 released without the button");
	AST_BUTTON_DROP: assert property (
		$rose(i_reset_button) && o_relay[0] |=> !o_relay[0])
		else $error("Button did not release relay 0");
	AST_OFF_NOT_EARLY: assert property (
		$fell(o_relay[2]) && o_off_delay[14:10] != 5'h00 && o_off_delay[14:10] != 5'h1f
		&& $past(o_monitoring) && !$past(i_reset_button) |-> off_run_reg >= off_min)
		else $error("Relay 2 released before its delay");
	AST_OFF_IN_TIME: assert property (
		o_off_delay[14:10] != 5'h00 && o_off_delay[14:10] != 5'h1f |-> off_run_reg <= off_max)
		else $error("Relay 2 held past its delay");
	AST_KEY_HALTS: assert property (
		key_held_s |-> o_relay == 3'h0 && !o_monitoring)
		else $error("Relays active with key in programming");
	AST_HOLD_ENTRY: assert property (
		$rose(i_programming_key_position) && i_reset_button && $past(i_reset_button)
		|=> o_restore_hold) else $error("Restore hold not armed");
	AST_HOLD_ABORT: assert property (
		o_restore_hold && !i_reset_button |=> !o_restore_hold && !o_restarting)
		else $error("Restore went on after button release");
	AST_HOLD_LEN: assert property (
		o_restore_hold |-> hold_reg <= RESTORE_HOLD_S * CYCLES_PER_SECOND + 32'h2)
		else $error("Restore hold lasted too long");
	AST_RESTART_RUN: assert property (
		$rose(o_restarting) |-> restart_run_s) else $error("Restart length wrong");
	AST_DEFAULTS: assert property (
		$rose(o_restarting) |=> o_on_delay == 15'h0000 && o_off_delay == 15'h7fff
		&& o_channel_used == 8'h0f && o_auxiliary_relay_mode == 3'h0
		&& o_first_alarm_threshold == 8'h0a && o_second_alarm_threshold == 8'h0f
		&& o_third_alarm_threshold == 8'h14 && o_hysteresis == 8'h03)
		else $error("Parameters not at factory values after restore");
endmodule : art_properties

bind alarm_relay_timing art_properties #(
	.CYCLES_PER_SECOND(CYCLES_PER_SECOND),
	.RESTORE_HOLD_S(RESTORE_HOLD_S)
) u_props (.i_clock, .i_rst_n, .i_threshold_output, .i_programming_key_position,
	.i_reset_button, .o_relay, .o_on_delay, .o_off_delay, .o_channel_used,
	.o_auxiliary_relay_mode, .o_first_alarm_threshold, .o_second_alarm_threshold,
	.o_third_alarm_threshold, .o_hysteresis, .o_monitoring, .o_restore_hold, .o_restarting);
`default_nettype wire

/* File: tb/art_panel_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Comparators and front panel in front of the block
// ----------------------------------------------------------------------------
module art_panel_model (
	// Clock
	input wire logic        i_clock,
	// Operator commands
	input wire logic [2:0]  i_alarm_cmd,
	input wire logic        i_key_cmd,
	input wire logic        i_button_cmd,
	// Lines into the block
	output logic     [2:0]  o_threshold_output,
	output logic            o_programming_key_position,
	output logic            o_reset_button
);
	initial begin
		o_threshold_output         = 3'h0;
		o_programming_key_position = 1'b0;
		o_reset_button             = 1'b0;
	end

	// Lines move just after the edge; the key only turns once a requested button is down
	always @(posedge i_clock) begin
		o_threshold_output         <= #1 i_alarm_cmd;
		o_reset_button             <= #1 i_button_cmd;
		o_programming_key_position <= #1 i_key_cmd && (o_programming_key_position
			|| !i_button_cmd || o_reset_button);
	end
endmodule : art_panel_model
`default_nettype wire

/* File: tb/test_alarm_relay_timing.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// Relay timing bench
// ----------------------------------------------------------------------------
module test_alarm_relay_timing;
	import art_pkg::*;
	localparam int unsigned CPS = 2;
	logic        i_clock, i_rst_n, key_cmd, button_cmd, key, button, par_write, mon, hold, busy;
	logic [2:0]  alarm_cmd, thr, relay, aux;
	logic [3:0]  par_addr;
	logic [7:0]  par_data, used, t1, t2, t3, hyst;
	logic [14:0] on_d, off_d;
	logic [4:0]  watch;
	int          fails, compares;
	assign watch = {busy, hold, relay};

	alarm_relay_timing #(.CYCLES_PER_SECOND(CPS), .RESTORE_HOLD_S(3)) dut (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_threshold_output(thr),
		.i_programming_key_position(key), .i_reset_button(button), .i_par_write(par_write),
		.i_par_addr(par_addr), .i_par_data(par_data), .o_relay(relay), .o_on_delay(on_d),
		.o_off_delay(off_d), .o_channel_used(used), .o_auxiliary_relay_mode(aux),
		.o_first_alarm_threshold(t1), .o_second_alarm_threshold(t2),
		.o_third_alarm_threshold(t3), .o_hysteresis(hyst), .o_monitoring(mon),
		.o_restore_hold(hold), .o_restarting(busy));
	art_panel_model panel (.i_clock(i_clock), .i_alarm_cmd(alarm_cmd), .i_key_cmd(key_cmd),
		.i_button_cmd(button_cmd), .o_threshold_output(thr),
		.o_programming_key_position(key), .o_reset_button(button));

	// Clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask : step
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("Compares %0d, fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// Bounded wait; running out counts as a mismatch and ends the run
	task automatic wait_for(input int idx, input logic val, input int lim, output int n);
		n = 0;
		while (watch[idx] !== val) begin
			if (n == lim) begin
				fails++;
				$display("Error at %0t: wait ran out, got %h expected %h", $time, watch[idx], val);
				stop_test();
			end
			step(1);
			n++;
		end
	endtask : wait_for
	task automatic write(input logic [3:0] a, input logic [7:0] d);
		par_addr  = a;
		par_data  = d;
		par_write = 1'b1;
		step(1);
		par_write = 1'b0;
		step(1);
	endtask : write
	task automatic chk_factory();
		chk({2'h0, on_d, off_d}, 32'h00007fff);
		chk({used, t1, t2, t3}, 32'h0f0a0f14);
		chk({21'h0, aux, hyst}, 32'h00000003);
	endtask : chk_factory

	task automatic t_latch();
		alarm_cmd = 3'h1;
		step(3);
		chk(relay[0], 1'b1);
		alarm_cmd = 3'h0;
		step(20);
		chk(relay[0], 1'b1);
		button_cmd = 1'b1;
		step(2);
		button_cmd = 1'b0;
		step(3);
		chk(relay[0], 1'b0);
		$display("Test latch done");
	endtask : t_latch
	task automatic t_key_halt();
		alarm_cmd = 3'h1;
		step(3);
		key_cmd = 1'b1;
		step(4);
		chk({relay, mon}, 4'h0);
		key_cmd = 1'b0;
		step(4);
		chk({relay[0], mon}, 2'h3);
		alarm_cmd = 3'h0;
		$display("Test key halt done");
	endtask : t_key_halt
	task automatic t_program();
		key_cmd = 1'b1;
		step(3);
		write(4'h1, 8'h01);
		write(4'h4, 8'h00);
		write(4'h5, 8'h02);
		write(4'h8, 8'h21);
		write(4'hc, 8'h55);
		write(4'h7, 8'h05);
		write(4'hb, 8'h07);
		key_cmd = 1'b0;
		step(3);
		// Key is off again, so this write must be ignored
		write(4'h9, 8'h44);
		chk({2'h0, on_d, off_d}, {17'h00020, 15'h081f});
		chk({used, t1, t2, t3}, 32'h0f210f14);
		chk({21'h0, aux, hyst}, 32'h00000507);
		$display("Test program done");
	endtask : t_program
	task automatic t_on_delay();
		int n;
		logic seen;
		alarm_cmd = 3'h2;
		wait_for(1, 1'b1, 400, n);
		chk(n >= 116 && n <= 126, 1'b1);
		alarm_cmd = 3'h0;
		step(3);
		chk(relay[1], 1'b0);
		alarm_cmd = 3'h2;
		step(60);
		alarm_cmd = 3'h0;
		seen = 1'b0;
		repeat (200) begin
			step(1);
			seen = seen | relay[1];
		end
		chk(seen, 1'b0);
		$display("Test on delay done");
	endtask : t_on_delay
	task automatic t_off_delay();
		int n;
		alarm_cmd = 3'h4;
		step(3);
		chk(relay[2], 1'b1);
		alarm_cmd = 3'h0;
		wait_for(2, 1'b0, 600, n);
		chk(n >= 235 && n <= 247, 1'b1);
		$display("Test off delay done");
	endtask : t_off_delay
	task automatic t_restore();
		int n;
		button_cmd = 1'b1;
		key_cmd    = 1'b1;
		wait_for(3, 1'b1, 10, n);
		button_cmd = 1'b0;
		key_cmd    = 1'b0;
		step(3);
		chk({hold, busy, off_d}, {2'h0, 15'h081f});
		button_cmd = 1'b1;
		key_cmd    = 1'b1;
		wait_for(4, 1'b1, 3 * CPS + 20, n);
		step(1);
		chk_factory();
		wait_for(4, 1'b0, 30, n);
		chk(n, 15);
		button_cmd = 1'b0;
		key_cmd    = 1'b0;
		step(3);
		chk({mon, relay}, 4'h8);
		$display("Test restore done");
	endtask : t_restore

	// Main sequence
	initial begin
		i_rst_n    = 1'b0;
		alarm_cmd  = 3'h0;
		key_cmd    = 1'b0;
		button_cmd = 1'b0;
		par_write  = 1'b0;
		par_addr   = 4'h0;
		par_data   = 8'h00;
		repeat (2) @(posedge i_clock);
		#1 i_rst_n = 1'b1;
		step(1);
		chk_factory();
		t_latch();
		t_key_halt();
		t_program();
		t_on_delay();
		t_off_delay();
		t_restore();
		stop_test();
	end
endmodule : test_alarm_relay_timing
`default_nettype wire
